// ---- rtl/bridge_retry_card_device_ctrl.sv ----
// Summary of operation
// RULE1: retry not reissued in 2^15 cycles sets expiry
// RULE2: expiry flag holds until software writes one
// RULE3: status bit 7 enables host retry timer
// RULE4: status bit 6 enables card retry timer
// RULE5: expiry flags at bits 5, 3, 1
// RULE6: status bits 4, 2, 0 read zero
// RULE7: sticky fields cleared only by global reset
// RULE8: card bit 7 gates ring indicate output
// RULE9: software preserves reserved card bits 6..3
// RULE10: card bit 2 turns off audio pwm route
// RULE11: card bit 1 routes speaker to output
// RULE12: card bit 0 flags functional irq, w1c
// RULE13: bit 7 blocks socket power-down in D3
// RULE14: device bit 6 forces low-volt capability report
// RULE15: device bit 5 diagnostic, resets to one
// RULE16: device bit 4 reads zero, ignores writes
// RULE17: software writes zero to device bit 3
// RULE18: device bits 2..1 select irq signalling mode
// RULE19: software writes zero to device bit 0
// RULE20: zero writes keep flags; set beats clear
// RULE21: timer runs from retry until reissue/disable
`timescale 1ns/1ps
`include "bridge_retry_card_defs.svh"

module bridge_retry_card_device_ctrl
  import bridge_retry_card_pkg::*;
#(
  parameter int RETRY_TIMEOUT_CYCLES = `RETRY_TIMEOUT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic global_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hostRetryReceived,
  input wire logic hostReissued,
  input wire logic cardARetryReceived,
  input wire logic cardAReissued,
  input wire logic cardBRetryReceived,
  input wire logic cardBReissued,
  input wire logic cardFuncIrqPin,
  input wire logic ringIndicatePin,
  input wire logic card_audio_signal,
  input wire logic card_speaker_signal,
  input wire logic powerDownRequest,
  input wire logic inD3,
  output logic ring_indicate_output,
  output logic ring_indicate_output_oe,
  output logic card_audio_pwm_out,
  output logic speaker_output_pin,
  output logic speaker_output_pin_oe,
  output logic socketPowerDown,
  output logic lowVoltCapable,
  output irq_mode_type irqSignallingMode
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // card-side pins arrive from outside the core clock domain
  logic [3:0] syncA_reg, syncB_reg, syncA_next, syncB_next;
  logic ringSync, audioSync, speakerSync, irqSync;
  logic irqSeen_reg, irqSeen_next;

  always_comb
  begin
    syncA_next = {ringIndicatePin, card_audio_signal, card_speaker_signal, cardFuncIrqPin};
    syncB_next = syncA_reg;
    irqSeen_next = syncB_reg[0];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
      irqSeen_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      irqSeen_reg <= irqSeen_next;
    end
  end

  assign ringSync = syncB_reg[3];
  assign audioSync = syncB_reg[2];
  assign speakerSync = syncB_reg[1];
  assign irqSync = syncB_reg[0];

  // ----------------------------------------------------------------
  // retry time-out timers
  // ----------------------------------------------------------------
  logic [7:0] retryStatus_reg, retryStatus_next;
  logic [7:0] cardControl_reg, cardControl_next;
  logic [7:0] deviceControl_reg, deviceControl_next;
  logic hostExpired, cardAExpired, cardBExpired;

  retry_timeout_timer #(.TIMEOUT_CYCLES(RETRY_TIMEOUT_CYCLES)) hostTimer (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(retryStatus_reg[`RS_HOST_EN_BIT]), // RULE3
    .retryReceived(hostRetryReceived),
    .reissued(hostReissued),
    .expired(hostExpired)
  );

  retry_timeout_timer #(.TIMEOUT_CYCLES(RETRY_TIMEOUT_CYCLES)) cardATimer (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(retryStatus_reg[`RS_CARD_EN_BIT]), // RULE4
    .retryReceived(cardARetryReceived),
    .reissued(cardAReissued),
    .expired(cardAExpired)
  );

  retry_timeout_timer #(.TIMEOUT_CYCLES(RETRY_TIMEOUT_CYCLES)) cardBTimer (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(retryStatus_reg[`RS_CARD_EN_BIT]), // RULE4
    .retryReceived(cardBRetryReceived),
    .reissued(cardBReissued),
    .expired(cardBExpired)
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // each register owns one aligned word at four times its index; data rides lane 0
  // the answer comes one cycle after setup, so there are never wait states
  function automatic logic hitReg(input logic [11:0] addr, input logic [11:0] regAddr);
    hitReg = (addr == regAddr);
  endfunction

  function automatic logic [7:0] w1cNext(input logic [7:0] cur, input logic [7:0] clr,
                                        input logic [7:0] setMask, input logic [7:0] flagMask);
    w1cNext = (cur & ~(clr & flagMask)) | (setMask & flagMask);
  endfunction

  logic wrAccess, rdAccess;
  logic rsHit, ccHit, dcHit, anyHit;
  logic wrRs, wrCc, wrDc;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic [7:0] wrByte, rdByte, setRs, setCc;

  always_comb
  begin
    rsHit = hitReg(paddr, `RETRY_STATUS_ADDR);
    ccHit = hitReg(paddr, `CARD_CONTROL_ADDR);
    dcHit = hitReg(paddr, `DEVICE_CONTROL_ADDR);
    anyHit = rsHit || ccHit || dcHit;
    // a write lands only at the edge where the master samples pready high
    wrAccess = psel && penable && pready && pwrite && pstrb[0];
    rdAccess = psel && !penable && !pwrite;
    wrRs = wrAccess && rsHit;
    wrCc = wrAccess && ccHit;
    wrDc = wrAccess && dcHit;
    wrByte = pwdata[7:0];
    setRs = 8'h00;
    setRs[`RS_TGT_B_BIT] = cardBExpired;
    setRs[`RS_TGT_A_BIT] = cardAExpired;
    setRs[`RS_HOST_EXP_BIT] = hostExpired;
    setCc = 8'h00;
    setCc[`CC_IRQ_FLAG_BIT] = irqSync && !irqSeen_reg; // RULE12
    // enables: plain read/write per byte lane
    retryStatus_next = retryStatus_reg;
    if (wrRs)
    begin
      retryStatus_next[`RS_HOST_EN_BIT] = wrByte[`RS_HOST_EN_BIT]; // RULE3
      retryStatus_next[`RS_CARD_EN_BIT] = wrByte[`RS_CARD_EN_BIT]; // RULE4
    end
    // set wins over write-one-clear
    retryStatus_next = w1cNext(retryStatus_next, wrRs ? wrByte : 8'h00,
                               setRs, 8'h2a); // RULE2 RULE5 RULE20
    retryStatus_next[4] = 1'b0; // RULE6
    retryStatus_next[2] = 1'b0; // RULE6
    retryStatus_next[0] = 1'b0; // RULE6
    cardControl_next = cardControl_reg;
    if (wrCc)
    begin
      // reserved bits 6..3 are kept as storage so a write-back reads true
      cardControl_next[7:1] = wrByte[7:1]; // RULE8 RULE10 RULE11
    end
    cardControl_next = w1cNext(cardControl_next, wrCc ? wrByte : 8'h00,
                               setCc, 8'h01); // RULE12 RULE20
    deviceControl_next = deviceControl_reg;
    if (wrDc)
    begin
      deviceControl_next = (wrByte & `DC_WMASK); // RULE16 RULE15 RULE18
    end
    deviceControl_next[4] = 1'b0; // RULE16
    rdByte = 8'h00;
    if (rsHit)
    begin
      rdByte = retryStatus_reg;
    end
    else if (ccHit)
    begin
      rdByte = cardControl_reg;
    end
    else if (dcHit)
    begin
      rdByte = deviceControl_reg;
    end
    prdata_next = 32'h0000_0000;
    if (rdAccess)
    begin
      prdata_next = {24'h00_0000, rdByte};
    end
    pready_next = psel && !penable;
    // unmapped words answer with an error and leave every register alone
    pslverr_next = psel && !penable && !anyHit;
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  // sticky control state rides the global reset only, not the bus reset
  always_ff @(posedge core_clk or negedge global_reset_n)
  begin
    if (!global_reset_n)
    begin
      retryStatus_reg <= `RS_RESET; // RULE7
      cardControl_reg <= `CC_RESET; // RULE7
      deviceControl_reg <= `DC_RESET; // RULE7
    end
    else
    begin
      retryStatus_reg <= retryStatus_next;
      cardControl_reg <= cardControl_next;
      deviceControl_reg <= deviceControl_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ----------------------------------------------------------------
  // card and socket outputs
  // ----------------------------------------------------------------
  logic ringOut_next, ringOe_next, audioOut_next, spkOut_next, spkOe_next;
  logic powerDown_next, lowVolt_next;
  irq_mode_type irqMode_next;

  always_comb
  begin
    ringOe_next = cardControl_reg[`CC_RING_EN_BIT]; // RULE8
    ringOut_next = cardControl_reg[`CC_RING_EN_BIT] && ringSync; // RULE8
    audioOut_next = !cardControl_reg[`CC_AUDIO_OFF_BIT] && audioSync; // RULE10
    spkOe_next = cardControl_reg[`CC_SPEAKER_BIT]; // RULE11
    spkOut_next = cardControl_reg[`CC_SPEAKER_BIT] && speakerSync; // RULE11
    powerDown_next = powerDownRequest && !(deviceControl_reg[`DC_HOLD_BIT] && inD3); // RULE13
    lowVolt_next = deviceControl_reg[`DC_LV_BIT]; // RULE14
    irqMode_next = irq_mode_type'(deviceControl_reg[`DC_MODE_LSB +: 2]); // RULE18
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ring_indicate_output <= 1'b0;
      ring_indicate_output_oe <= 1'b0;
      card_audio_pwm_out <= 1'b0;
      speaker_output_pin <= 1'b0;
      speaker_output_pin_oe <= 1'b0;
      socketPowerDown <= 1'b0;
      lowVoltCapable <= 1'b1;
      irqSignallingMode <= IRQ_SERIAL_ALL;
    end
    else
    begin
      ring_indicate_output <= ringOut_next;
      ring_indicate_output_oe <= ringOe_next;
      card_audio_pwm_out <= audioOut_next;
      speaker_output_pin <= spkOut_next;
      speaker_output_pin_oe <= spkOe_next;
      socketPowerDown <= powerDown_next;
      lowVoltCapable <= lowVolt_next;
      irqSignallingMode <= irqMode_next;
    end
  end

endmodule // bridge_retry_card_device_ctrl

// ---- rtl/bridge_retry_card_defs.svh ----
`ifndef BRIDGE_RETRY_CARD_DEFS_SVH
`define BRIDGE_RETRY_CARD_DEFS_SVH

`define RETRY_STATUS_ADDR 12'h240
`define CARD_CONTROL_ADDR 12'h244
`define DEVICE_CONTROL_ADDR 12'h248

`define RETRY_STATUS_INDEX 8'h90
`define CARD_CONTROL_INDEX 8'h91
`define DEVICE_CONTROL_INDEX 8'h92

`define RS_HOST_EN_BIT 7
`define RS_CARD_EN_BIT 6
`define RS_TGT_B_BIT 5
`define RS_TGT_A_BIT 3
`define RS_HOST_EXP_BIT 1
`define RS_RESET 8'hc0

`define CC_RING_EN_BIT 7
`define CC_AUDIO_OFF_BIT 2
`define CC_SPEAKER_BIT 1
`define CC_IRQ_FLAG_BIT 0
`define CC_RSVD_MASK 8'h78
`define CC_RESET 8'h00

`define DC_HOLD_BIT 7
`define DC_LV_BIT 6
`define DC_DIAG_BIT 5
`define DC_TEST_BIT 3
`define DC_MODE_LSB 1
`define DC_RSVD0_BIT 0
`define DC_WMASK 8'hef
`define DC_RESET 8'h66

`define RETRY_TIMEOUT_EXP 15
`define RETRY_TIMEOUT_CYCLES 32768

`endif

// ---- rtl/bridge_retry_card_pkg.sv ----
package bridge_retry_card_pkg;

  typedef enum logic [1:0] {
    IRQ_PARALLEL_ONLY = 2'b00,
    IRQ_RESERVED = 2'b01,
    IRQ_SERIAL_PLUS_PARALLEL = 2'b10,
    IRQ_SERIAL_ALL = 2'b11
  } irq_mode_type;

  typedef enum logic {
    TIMER_IDLE,
    TIMER_RUN
  } timer_state_type;

endpackage

// ---- rtl/retry_timeout_timer.sv ----
`timescale 1ns/1ps
`include "bridge_retry_card_defs.svh"

module retry_timeout_timer
  import bridge_retry_card_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `RETRY_TIMEOUT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic retryReceived,
  input wire logic reissued,
  output logic expired
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

  timer_state_type state_reg, state_next;
  logic [CW-1:0] count_reg, count_next;
  logic expired_reg, expired_next;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    expired_next = 1'b0;
    unique case (state_reg)
      TIMER_IDLE:
      begin
        count_next = '0;
        if (enable && retryReceived && !reissued) // RULE21
        begin
          state_next = TIMER_RUN;
        end
      end
      TIMER_RUN:
      begin
        if (!enable || reissued) // RULE21
        begin
          state_next = TIMER_IDLE;
          count_next = '0;
        end
        else if (count_reg == CW'(TIMEOUT_CYCLES - 1)) // RULE1
        begin
          expired_next = 1'b1;
          state_next = TIMER_IDLE;
          count_next = '0;
        end
        else
        begin
          count_next = count_reg + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= TIMER_IDLE;
      count_reg <= '0;
      expired_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule // retry_timeout_timer

// ---- verification/bridge_retry_card_device_ctrl_assertions.sv ----
`timescale 1ns/1ps
module bridge_retry_card_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic powerDownRequest,
  input wire logic ring_indicate_output,
  input wire logic ring_indicate_output_oe,
  input wire logic speaker_output_pin,
  input wire logic speaker_output_pin_oe,
  input wire logic socketPowerDown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; psel && penable && pready; endsequence
  property p_zero_wait; s_setup |=> s_answer; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_cause;
    pready && pslverr |-> paddr != 12'h240 && paddr != 12'h244 && paddr != 12'h248;
  endproperty
  property p_mapped_ok;
    pready && (paddr == 12'h240 || paddr == 12'h244 || paddr == 12'h248) |-> !pslverr;
  endproperty
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_rsvd_zero;
    pready && !pwrite && !pslverr |->
      prdata[31:8] == 24'h0 &&
      (paddr != 12'h240 || (!prdata[4] && !prdata[2] && !prdata[0])) &&
      (paddr != 12'h248 || !prdata[4]);
  endproperty
  property p_ring_gate; ring_indicate_output |-> ring_indicate_output_oe; endproperty
  property p_spk_gate; speaker_output_pin |-> speaker_output_pin_oe; endproperty
  property p_pwr_cause; socketPowerDown |-> $past(powerDownRequest); endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("no zero-wait answer");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_cause: assert property (p_err_cause)
    else $error("error on mapped word");
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped word refused");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read not zero");
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit reads one");
  a_ring_gate: assert property (p_ring_gate)
    else $error("ring output without enable");
  a_spk_gate: assert property (p_spk_gate)
    else $error("speaker drives without enable");
  a_pwr_cause: assert property (p_pwr_cause)
    else $error("power-down without request");
endmodule // bridge_retry_card_checker

bind bridge_retry_card_device_ctrl bridge_retry_card_checker chk_u (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .powerDownRequest(powerDownRequest), .ring_indicate_output(ring_indicate_output),
  .ring_indicate_output_oe(ring_indicate_output_oe), .speaker_output_pin(speaker_output_pin),
  .speaker_output_pin_oe(speaker_output_pin_oe), .socketPowerDown(socketPowerDown)
);

// ---- verification/retry_partner.sv ----
`timescale 1ns/1ps
module retry_partner #(
  parameter int LAG = 4
)
(
  input wire logic core_clk,
  input wire logic [2:0] kick,
  input wire logic [2:0] answer,
  output logic [2:0] retryReceived,
  output logic [2:0] reissued
);
  // targets: 0 host, 1 card a, 2 card b; a target told to answer reissues LAG cycles late
  logic [2:0] pend = 3'h0;
  int cnt = 0;
  initial retryReceived = 3'h0;
  initial reissued = 3'h0;
  always @(posedge core_clk)
  begin
    retryReceived <= kick;
    reissued <= 3'h0;
    if (|(kick & answer))
    begin
      pend <= kick & answer;
      cnt <= LAG;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
        reissued <= pend;
    end
  end
endmodule // retry_partner

// ---- verification/bridge_retry_card_device_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module bridge_retry_card_device_ctrl_tb_top
  import bridge_retry_card_pkg::*;
;
  localparam int TMO = 16;
  localparam logic [11:0] RS = 12'h240;
  localparam logic [11:0] CC = 12'h244;
  localparam logic [11:0] DC = 12'h248;
  logic core_clk = 0, resetn = 0, global_reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, rerr, ringOut, ringOe, audioOut, spkOut, spkOe, pwrDown, lvCap;
  logic [2:0] kick = 3'h0, answer = 3'h0, retryReceived, reissued;
  logic irqPin = 0, ringPin = 0, audioPin = 0, spkPin = 0, powerDownRequest = 0, inD3 = 0;
  irq_mode_type irqMode;
  int miscompares = 0, compares = 0;
  always #4 core_clk = ~core_clk;
  retry_partner #(.LAG(TMO - 4)) partner_u (.core_clk(core_clk), .kick(kick),
    .answer(answer), .retryReceived(retryReceived), .reissued(reissued));
  bridge_retry_card_device_ctrl #(.RETRY_TIMEOUT_CYCLES(TMO)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .global_reset_n(global_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hostRetryReceived(retryReceived[0]), .hostReissued(reissued[0]),
    .cardARetryReceived(retryReceived[1]), .cardAReissued(reissued[1]),
    .cardBRetryReceived(retryReceived[2]), .cardBReissued(reissued[2]),
    .cardFuncIrqPin(irqPin), .ringIndicatePin(ringPin), .card_audio_signal(audioPin),
    .card_speaker_signal(spkPin), .powerDownRequest(powerDownRequest), .inD3(inD3),
    .ring_indicate_output(ringOut), .ring_indicate_output_oe(ringOe),
    .card_audio_pwm_out(audioOut), .speaker_output_pin(spkOut), .speaker_output_pin_oe(spkOe),
    .socketPowerDown(pwrDown), .lowVoltCapable(lvCap), .irqSignallingMode(irqMode));
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] b);
    bus(1'b1, a, {24'h00_0000, b}, 4'h1);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic burst(input logic [2:0] ans);
    answer <= ans;
    kick <= 3'h7;
    cyc(1);
    kick <= 3'h0;
    cyc(TMO + 8);
    rd(RS);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_retry;
    rd(RS);
    chk(rdat, 32'h0000_00c0);
    rd(CC);
    chk(rdat, 32'h0000_0000);
    rd(DC);
    chk(rdat, 32'h0000_0066);
    chk(32'({lvCap, irqMode}), 32'h7);
    burst(3'h0);
    chk(rdat[7:0], 8'hea);
    wr(RS, 8'hc0);
    rd(RS);
    chk(rdat[7:0], 8'hea);
    wr(RS, 8'he0);
    rd(RS);
    chk(rdat[7:0], 8'hca);
    wr(RS, 8'hca);
    burst(3'h7);
    chk(rdat[7:0], 8'hc0);
    wr(RS, 8'h00);
    burst(3'h0);
    chk(rdat[7:0], 8'h00);
    wr(RS, 8'hc0);
    burst(3'h0);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd(RS);
    chk(rdat[7:0], 8'hea);
    global_reset_n <= 1'b0;
    cyc(2);
    global_reset_n <= 1'b1;
    rd(RS);
    chk(rdat, 32'h0000_00c0);
    rd(CC);
    chk(rdat, 32'h0000_0000);
    rd(DC);
    chk(rdat, 32'h0000_0066);
  endtask
  task automatic t_card;
    ringPin <= 1'b1;
    audioPin <= 1'b1;
    spkPin <= 1'b1;
    wr(CC, 8'h86);
    cyc(4);
    chk(32'({ringOut, ringOe, spkOut, spkOe, audioOut}), 32'h1e);
    wr(CC, 8'h00);
    cyc(4);
    chk(32'({ringOut, ringOe, spkOut, spkOe, audioOut}), 32'h01);
    irqPin <= 1'b1;
    cyc(5);
    wr(CC, 8'h00);
    rd(CC);
    chk(rdat[7:0], 8'h01);
    wr(CC, 8'h01);
    rd(CC);
    chk(rdat[7:0], 8'h00);
  endtask
  task automatic t_device;
    logic [7:0] dv;
    for (int m = 0; m < 4; m++)
    begin
      dv = {1'b1, 1'(m), 2'b11, 1'b0, 2'(m), 1'b0};
      wr(DC, dv);
      cyc(2);
      rd(DC);
      chk(rdat[7:0], dv & 8'hef);
      chk(32'({lvCap, irqMode}), 32'({dv[6], dv[2:1]}));
    end
    inD3 <= 1'b1;
    powerDownRequest <= 1'b1;
    cyc(3);
    chk(32'(pwrDown), 32'h0);
    inD3 <= 1'b0;
    cyc(3);
    chk(32'(pwrDown), 32'h1);
    bus(1'b1, 12'h094, 32'hffff_ffff, 4'hf);
    chk(32'(rerr), 32'h1);
    bus(1'b0, 12'h094, 32'h0, 4'h0);
    chk(rdat, 32'h0);
  endtask
  task automatic summarize;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    cyc(20);
    resetn <= 1'b1;
    global_reset_n <= 1'b1;
    t_retry;
    t_card;
    t_device;
    summarize;
  end
  initial
  begin
    cyc(5000);
    miscompares++;
    summarize;
  end
endmodule // bridge_retry_card_device_ctrl_tb_top
